//--- hw/tbu_ras_error_record_regs.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module tbu_ras_error_record_regs
  import tbu_ras_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sec_override,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ce_mtlb_pin,
  input wire logic ce_wdb_pin,
  input wire logic ue_pin,
  input wire logic de_pin,
  output logic [15:0] feature_disable_control,
  output logic fault_irq,
  output logic irq
);
  // two-flop synchronisers on the error event inputs
  logic [3:0] ev_s1_q, ev_s2_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ev_s1_q <= 4'h0;
      ev_s2_q <= 4'h0;
    end else begin
      ev_s1_q <= {de_pin, ue_pin, ce_wdb_pin, ce_mtlb_pin};
      ev_s2_q <= ev_s1_q;
    end
  end

  // strap capture happens one cycle after reset release, never under reset
  logic strap_pend_q;
  logic [1:0] sec_ctrl_q;
  logic [31:0] err_control_q;
  logic [15:0] feat_ctrl_q;
  logic [IRQ_W-1:0] irq_stat_q, irq_mask_q;

  // APB decode; single-cycle access, no wait states
  logic [ADDR_W-1:0] addr;
  logic acc, wr, rd, nonsec, full_wr;
  logic in_ras, ras_ok, uarch_ok;
  logic hit_feat, hit_econ, hit_stat, hit_inj, hit_sec, hit_fctl;
  logic hit_irqs, hit_irqm;
  localparam logic [16:0] OFF_IRQ_STAT = 17'h08ED0;
  localparam logic [16:0] OFF_IRQ_MASK = 17'h08ED4;

  assign addr = paddr[ADDR_W-1:0];
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign nonsec = pprot[1];
  // partial writes are ignored: every register is a full word
  assign full_wr = wr && (pstrb == 4'hF);
  assign in_ras = (addr >= RAS_RANGE_LO) && (addr <= RAS_RANGE_HI);
  assign ras_ok = !nonsec || sec_ctrl_q[SEC_RAS_BIT];
  assign uarch_ok = !nonsec || sec_ctrl_q[SEC_UARCH_BIT];
  assign hit_feat = (addr == OFF_ERR_FEATURE) && ras_ok && !nonsec;
  assign hit_econ = (addr == OFF_ERR_CONTROL) && ras_ok;
  assign hit_stat = (addr == OFF_ERR_STATUS) && ras_ok;
  assign hit_inj = (addr == OFF_ERR_INJECT) && ras_ok;
  assign hit_fctl = (addr == OFF_FEATURE_CTRL) && uarch_ok;
  assign hit_sec = (addr == OFF_SEC_CTRL) && !nonsec;
  assign hit_irqs = (addr == OFF_IRQ_STAT) && !nonsec;
  assign hit_irqm = (addr == OFF_IRQ_MASK) && !nonsec;
  assign pready = 1'b1;
  // addresses outside the ras window and the four extra registers error; RAZ/WI denials complete cleanly
  assign pslverr = acc && !in_ras && (addr != OFF_FEATURE_CTRL)
    && (addr != OFF_SEC_CTRL) && (addr != OFF_IRQ_STAT)
    && (addr != OFF_IRQ_MASK);

  // error record
  logic [31:0] status;
  logic new_err, new_ue, new_of;
  err_record u_rec (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce_mtlb(ev_s2_q[0]),
    .ce_wdb(ev_s2_q[1]),
    .ue_err(ev_s2_q[2]),
    .de_err(ev_s2_q[3]),
    .clr_we(full_wr && hit_stat),
    .clr_data(pwdata),
    .inj_we(full_wr && hit_inj),
    .inj_data(pwdata),
    .status(status),
    .new_err(new_err),
    .new_ue(new_ue),
    .new_of(new_of)
  );

  // secure control; loaded from the tie-off after reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      strap_pend_q <= 1'b1;
      sec_ctrl_q <= 2'b00;
    end else if (strap_pend_q) begin
      strap_pend_q <= 1'b0;
      sec_ctrl_q <= {2{sec_override}};
    end else if (full_wr && hit_sec) begin
      sec_ctrl_q <= pwdata[1:0];
    end
  end

  // error control, fault enable and bit 0 kept; other bits read as zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      err_control_q <= ERR_CONTROL_RST;
    else if (full_wr && hit_econ)
      err_control_q <= pwdata & ERR_CONTROL_MASK;
  end

  // feature-disable control: bit 0 sticky once set
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      feat_ctrl_q <= 16'h0000;
    else if (full_wr && hit_fctl)
      feat_ctrl_q <= {pwdata[15:1], pwdata[0] | feat_ctrl_q[0]};
  end
  assign feature_disable_control = feat_ctrl_q;

  // sticky interrupt status, cleared by reading; new event wins
  logic [IRQ_W-1:0] ev_vec;
  assign ev_vec = {new_of, new_ue, new_err && !new_ue};
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
    end else begin
      if (rd && hit_irqs)
        irq_stat_q <= ev_vec;
      else
        irq_stat_q <= irq_stat_q | ev_vec;
      if (full_wr && hit_irqm)
        irq_mask_q <= pwdata[IRQ_W-1:0];
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // fault interrupt is a level on the recorded record and enable
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      fault_irq <= 1'b0;
    else
      fault_irq <= status[ST_V] && err_control_q[FI_BIT];
  end

  // read mux; denied reads return zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (hit_feat)
        prdata <= ERR_FEATURE_VAL;
      else if (hit_econ)
        prdata <= err_control_q;
      else if (hit_stat)
        prdata <= status;
      else if (hit_fctl)
        prdata <= {16'h0000, feat_ctrl_q};
      else if (hit_sec)
        prdata <= {30'h0, sec_ctrl_q};
      else if (hit_irqs)
        prdata <= {29'h0, irq_stat_q};
      else if (hit_irqm)
        prdata <= {29'h0, irq_mask_q};
    end
  end
endmodule

//--- shared/tbu_ras_pkg.sv
package tbu_ras_pkg;
  // register byte offsets (low 17 bits of the page)
  localparam logic [16:0] OFF_FEATURE_CTRL = 17'h08E00;
  localparam logic [16:0] OFF_ERR_FEATURE = 17'h08E80;
  localparam logic [16:0] OFF_ERR_CONTROL = 17'h08E88;
  localparam logic [16:0] OFF_ERR_STATUS = 17'h08E90;
  localparam logic [16:0] OFF_ERR_INJECT = 17'h08EA0;
  localparam logic [16:0] OFF_SEC_CTRL = 17'h08EC4;
  localparam logic [16:0] RAS_RANGE_LO = 17'h08E80;
  localparam logic [16:0] RAS_RANGE_HI = 17'h08EC0;
  localparam int ADDR_W = 17;

  // secure control bits
  localparam int SEC_UARCH_BIT = 0;
  localparam int SEC_RAS_BIT = 1;

  // feature register: fixed content
  localparam logic [1:0] FEAT_CI = 2'h1;
  localparam logic [1:0] FEAT_DUI = 2'h0;
  localparam logic [2:0] FEAT_CEC = 3'h0;
  localparam logic [1:0] FEAT_CFI = 2'h0;
  localparam logic [1:0] FEAT_UE = 2'h0;
  localparam logic [1:0] FEAT_FI = 2'h2;
  localparam logic [1:0] FEAT_UI = 2'h1;
  localparam logic [1:0] FEAT_ED = 2'h1;
  localparam logic [31:0] ERR_FEATURE_VAL = {8'h00, FEAT_CI, 4'h0, FEAT_DUI,
    1'b0, FEAT_CEC, FEAT_CFI, FEAT_UE, FEAT_FI, FEAT_UI, 2'h0, FEAT_ED};

  // control register
  localparam int FI_BIT = 3;
  localparam logic [31:0] ERR_CONTROL_RST = 32'h0000_0001;
  localparam logic [31:0] ERR_CONTROL_MASK = 32'h0000_0009;
  localparam logic [31:0] FEATURE_CTRL_MASK = 32'h0000_FFFF;

  // status fields
  localparam int ST_V = 30;
  localparam int ST_UE = 29;
  localparam int ST_OF = 27;
  localparam int ST_CE_HI = 25;
  localparam int ST_CE_LO = 24;
  localparam int ST_DE = 23;
  localparam int ST_UET_HI = 21;
  localparam int ST_UET_LO = 20;
  localparam logic [1:0] CE_NONE = 2'h0;
  localparam logic [1:0] CE_SOME = 2'h2;
  localparam logic [1:0] UET_UC = 2'h0;

  // interrupt status / mask bits
  localparam int IRQ_W = 3;
  localparam int EV_CE = 0;
  localparam int EV_UE = 1;
  localparam int EV_OF = 2;
endpackage

//--- hw/err_record.sv
`timescale 1ns/1ps
// error record status register with write-one-to-clear race protection
module err_record
  import tbu_ras_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce_mtlb,
  input wire logic ce_wdb,
  input wire logic ue_err,
  input wire logic de_err,
  input wire logic clr_we,
  input wire logic [31:0] clr_data,
  input wire logic inj_we,
  input wire logic [31:0] inj_data,
  output logic [31:0] status,
  output logic new_err,
  output logic new_ue,
  output logic new_of
);
  logic v_q, ue_q, of_q, de_q;
  logic [1:0] ce_q;
  logic any_err, multi_err, clr_ok, clr_v, inj_ok;
  logic [2:0] cnt;

  // count simultaneous arrivals
  always_comb begin
    cnt = {2'b00, ce_mtlb} + {2'b00, ce_wdb} + {2'b00, ue_err}
        + {2'b00, de_err};
    any_err = (cnt != 3'h0);
    multi_err = (cnt > 3'h1);
  end

  // a clear is ignored in a cycle where a new error lands, since software
  // has not seen it yet
  assign clr_ok = clr_we && !any_err;
  assign clr_v = clr_ok && clr_data[ST_V];
  // injection valid: V set, UE/DE with legal CE or CE=10, UNCORRECTED_TYPE zero
  assign inj_ok = inj_we && inj_data[ST_V]
    && inj_data[ST_UET_HI:ST_UET_LO] == UET_UC
    && ((inj_data[ST_CE_HI:ST_CE_LO] == CE_SOME)
      || ((inj_data[ST_UE] || inj_data[ST_DE])
        && inj_data[ST_CE_HI:ST_CE_LO] == CE_NONE));

  // record update; hardware set wins over software clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      v_q <= 1'b0;
      ue_q <= 1'b0;
      of_q <= 1'b0;
      de_q <= 1'b0;
      ce_q <= CE_NONE;
    end else if (inj_ok) begin
      v_q <= 1'b1;
      ue_q <= inj_data[ST_UE];
      of_q <= inj_data[ST_OF];
      de_q <= inj_data[ST_DE];
      ce_q <= inj_data[ST_CE_HI:ST_CE_LO];
    end else begin
      if (any_err)
        v_q <= 1'b1;
      else if (clr_v)
        v_q <= 1'b0;
      if (ue_err)
        ue_q <= 1'b1;
      else if (clr_ok && clr_data[ST_UE])
        ue_q <= 1'b0;
      if (de_err)
        de_q <= 1'b1;
      else if (clr_ok && clr_data[ST_DE])
        de_q <= 1'b0;
      if (multi_err || (any_err && v_q && !clr_v))
        of_q <= 1'b1;
      else if (clr_ok && clr_data[ST_OF])
        of_q <= 1'b0;
      if (ce_mtlb || ce_wdb)
        ce_q <= CE_SOME;
      else if (clr_ok && clr_data[ST_CE_HI])
        ce_q <= CE_NONE;
    end
  end

  // uncorrected type always reads uncontainable; writes ignored
  always_comb begin
    status = 32'h0000_0000;
    status[ST_V] = v_q;
    status[ST_UE] = ue_q;
    status[ST_OF] = of_q;
    status[ST_CE_HI:ST_CE_LO] = ce_q;
    status[ST_DE] = de_q;
    status[ST_UET_HI:ST_UET_LO] = UET_UC;
  end

  assign new_err = any_err || inj_ok;
  assign new_ue = ue_err || (inj_ok && inj_data[ST_UE]);
  assign new_of = multi_err || (any_err && v_q && !clr_v)
    || (inj_ok && inj_data[ST_OF]);
endmodule

//--- test/ras_regs_sva.sv
`timescale 1ns/1ps
// pin-level watch on the register block
module ras_regs_checker
  import tbu_ras_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [2:0] pprot,
  input wire logic [31:0] prdata,
  input wire logic ce_mtlb_pin,
  input wire logic ce_wdb_pin,
  input wire logic ue_pin,
  input wire logic de_pin,
  input wire logic [15:0] feature_disable_control,
  input wire logic fault_irq,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // access phase, feature read setup and any raw event
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite;
  wire logic frd = psel && !penable && !pwrite
    && paddr == {15'h0, OFF_ERR_FEATURE};
  wire logic ev = ce_mtlb_pin || ce_wdb_pin || ue_pin || de_pin;
  chk_feat_value: assert property (frd && !pprot[1] |=>
    prdata == ERR_FEATURE_VAL) else $error("feature word wrong");
  chk_feat_ns_zero: assert property (frd && pprot[1] |=>
    prdata == 32'h0) else $error("feature seen by non-secure");
  chk_fault_hold: assert property (fault_irq && !wr && !$past(wr)
    |=> fault_irq) else $error("fault irq dropped alone");
  chk_fault_cause: assert property ($rose(fault_irq) |->
    $past(ev, 4) || $past(wr, 2)) else $error("fault irq without cause");
  chk_irq_cause: assert property ($rose(irq) |->
    $past(ev, 3) || $past(wr)) else $error("irq without cause");
  chk_irq_fall: assert property ($fell(irq) |->
    $past(acc)) else $error("irq fell without access");
  chk_ctrl_stable: assert property (!$past(wr) |->
    $stable(feature_disable_control)) else $error("ctrl moved");
  chk_fault_reset: assert property ($rose(rst_n) |->
    !fault_irq) else $error("fault irq after reset");
  // main scenarios
  cover property ($rose(fault_irq));
  cover property ($rose(irq));
  cover property (frd && pprot[1]);
endmodule

//--- test/tbu_ras_error_record_regs_tb.sv
`timescale 1ns/1ps
module tbu_ras_error_record_regs_tb;
  import tbu_ras_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] pprot = 3'h0;
  logic [3:0] ev = 4'h0;
  logic sec_ovr = 1'b0;
  logic [31:0] prdata, rd, r;
  logic pready, pslverr, fault_irq, irq, serr;
  logic [15:0] fdc;
  int error_cnt = 0;
  int num_checks = 0;
  int seed = 94856;
  localparam logic [16:0] IRQ_ST = 17'h08ED0;
  localparam logic [16:0] IRQ_MASK = 17'h08ED4;
  localparam logic [31:0] CLR = 32'hFFFF_FFFF;
  tbu_ras_error_record_regs DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .sec_override(sec_ovr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pprot(pprot),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ce_mtlb_pin(ev[0]), .ce_wdb_pin(ev[1]), .ue_pin(ev[2]),
    .de_pin(ev[3]), .feature_disable_control(fdc),
    .fault_irq(fault_irq), .irq(irq));
  // 250 MHz
  always #2 ref_clk = ~ref_clk;
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // request held until pready is sampled high
  task apb(input logic w, input logic [16:0] a, input logic [31:0] d,
    input logic ns);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {15'h0, a};
    pwdata <= d;
    pprot <= {1'b0, ns, 1'b0};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) error_cnt++;
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input logic [16:0] a, input logic ns, input logic [31:0] e);
    apb(1'b0, a, 32'h0, ns);
    check(rd, e);
  endtask
  // one-cycle pin pulse, then room for sync and record
  task pulse(input logic [3:0] m);
    @(posedge ref_clk);
    ev <= m;
    @(posedge ref_clk);
    ev <= 4'h0;
    repeat (5) @(posedge ref_clk);
  endtask
  function logic [31:0] st(input logic v, unc, ovf, dfr,
    input logic [1:0] cor);
    return (32'(v) << ST_V) | (32'(unc) << ST_UE) | (32'(ovf) << ST_OF)
      | (32'(cor) << ST_CE_LO) | (32'(dfr) << ST_DE);
  endfunction
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // watchdog: the sequence needs well under 1000 cycles
  initial begin
    #20000;
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rdchk(OFF_ERR_FEATURE, 1'b0, 32'h0040_0091);
    rdchk(OFF_ERR_CONTROL, 1'b0, 32'h1);
    rdchk(OFF_ERR_STATUS, 1'b0, 32'h0);
    rdchk(OFF_SEC_CTRL, 1'b0, 32'h0);
    apb(1'b1, OFF_ERR_CONTROL, 32'h9, 1'b1);
    rdchk(OFF_ERR_CONTROL, 1'b0, 32'h1);
    apb(1'b1, OFF_FEATURE_CTRL, 32'hAB, 1'b1);
    rdchk(OFF_FEATURE_CTRL, 1'b1, 32'h0);
    check(32'(fdc), 32'h0);
    apb(1'b1, OFF_SEC_CTRL, CLR, 1'b0);
    rdchk(OFF_SEC_CTRL, 1'b0, 32'h3);
    apb(1'b1, OFF_FEATURE_CTRL, 32'hAB, 1'b1);
    rdchk(OFF_ERR_FEATURE, 1'b1, 32'h0);
    check(32'(fdc), 32'hAB);
    $display("access control done");
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      apb(1'b1, OFF_ERR_CONTROL, r, 1'b0);
      rdchk(OFF_ERR_CONTROL, 1'b0, r & 32'h9);
    end
    apb(1'b1, OFF_ERR_CONTROL, 32'h9, 1'b0);
    apb(1'b1, IRQ_MASK, 32'h7, 1'b0);
    pulse(4'h1);
    rdchk(OFF_ERR_STATUS, 1'b0, st(1, 0, 0, 0, 2'h2));
    check(32'(fault_irq), 32'h1);
    pulse(4'h2);
    rdchk(OFF_ERR_STATUS, 1'b0, st(1, 0, 1, 0, 2'h2));
    check(32'(irq), 32'h1);
    rdchk(IRQ_ST, 1'b0, 32'h5);
    rdchk(IRQ_ST, 1'b0, 32'h0);
    check(32'(fault_irq & ~irq), 32'h1);
    apb(1'b1, OFF_ERR_STATUS, CLR, 1'b0);
    rdchk(OFF_ERR_STATUS, 1'b0, 32'h0);
    check(32'(fault_irq), 32'h0);
    pulse(4'hC);
    rdchk(OFF_ERR_STATUS, 1'b0, st(1, 1, 1, 1, 2'h0));
    $display("event recording done");
    // clear lands in the cycle a new event reaches the record
    fork
      pulse(4'h1);
      begin
        @(posedge ref_clk);
        apb(1'b1, OFF_ERR_STATUS, CLR, 1'b0);
      end
    join
    rdchk(OFF_ERR_STATUS, 1'b0, st(1, 1, 1, 1, 2'h2));
    // ue+de pair and the racing ce both left sticky events behind
    rdchk(IRQ_ST, 1'b0, 32'h7);
    apb(1'b1, OFF_ERR_STATUS, CLR, 1'b0);
    apb(1'b1, OFF_ERR_INJECT, st(0, 1, 0, 0, 2'h0), 1'b0);
    rdchk(OFF_ERR_STATUS, 1'b0, 32'h0);
    apb(1'b1, OFF_ERR_INJECT, st(1, 1, 0, 0, 2'h0), 1'b0);
    rdchk(OFF_ERR_STATUS, 1'b0, st(1, 1, 0, 0, 2'h0));
    check(32'(fault_irq), 32'h1);
    apb(1'b1, IRQ_MASK, 32'h0, 1'b0);
    rdchk(IRQ_ST, 1'b0, 32'h2);
    pulse(4'h1);
    check(32'(irq), 32'h0);
    rdchk(IRQ_ST, 1'b0, 32'h5);
    // unmapped word outside the ras window must flag an error
    apb(1'b0, 17'h08F00, 32'h0, 1'b0);
    check(32'(serr), 32'h1);
    $display("race, injection and mask done");
    // second reset with the tie-off high: both permits open at start
    @(posedge ref_clk);
    sec_ovr <= 1'b1;
    rst_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rdchk(OFF_SEC_CTRL, 1'b0, 32'h3);
    rdchk(OFF_ERR_STATUS, 1'b1, 32'h0);
    rdchk(OFF_ERR_CONTROL, 1'b1, 32'h1);
    check(32'(fdc), 32'h0);
    // keep the uarch permit clear, as secure translation may run
    apb(1'b1, OFF_SEC_CTRL, 32'h2, 1'b0);
    apb(1'b1, OFF_FEATURE_CTRL, 32'h5, 1'b1);
    check(32'(fdc), 32'h0);
    rdchk(OFF_ERR_CONTROL, 1'b1, 32'h1);
    $display("second reset done");
    summarize();
  end
endmodule
bind tbu_ras_error_record_regs ras_regs_checker u_chk (.ref_clk(ref_clk),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pprot(pprot), .prdata(prdata), .ce_mtlb_pin(ce_mtlb_pin),
  .ce_wdb_pin(ce_wdb_pin), .ue_pin(ue_pin), .de_pin(de_pin),
  .feature_disable_control(feature_disable_control),
  .fault_irq(fault_irq), .irq(irq));
